// ===== src/ioexp_pkg.sv
// Operation
// - A read of the pin value field returns the cached pin image of the selected expander.
// - Pin value writes are dropped while the override test bit is clear.
// - In test mode the selected expander outputs come from the written pin values.
// - Pin value bits that map to expander inputs never take writes.
// - Writing one to the refresh bit starts a transaction that refreshes the expander image.
// - The refresh bit is a trigger and always reads as zero.
// - The override test bit makes the core outputs ignored; written values go out on refresh.
// - The select field picks expander zero to four; other codes are reserved.
// - The completion flag is set when the selected expander transaction ends; write one clears.
// - Every transaction uses the 7-bit bus address held for that expander.
package ioexp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [11:0] IOEXP_CTRL_OFS  = 12'h0430;
	localparam logic [11:0] IOEXP_ADDR0_OFS = 12'h0434;
	localparam logic [11:0] IOEXP_ADDR1_OFS = 12'h0438;
	localparam logic [11:0] IOEXP_IRQST_OFS = 12'h0440;
	localparam logic [11:0] IOEXP_IRQMK_OFS = 12'h0444;

	////////////////////////////////////////////////////////////////////////////
	// Control and address register fields
	localparam int IOEXP_PIN_W       = 16;
	localparam int IOEXP_REFRESH_BIT = 24;
	localparam int IOEXP_TEST_BIT    = 25;
	localparam int IOEXP_SEL_LSB     = 26;
	localparam int IOEXP_SEL_W       = 4;
	localparam int IOEXP_DONE_BIT    = 31;
	localparam int IOEXP_BUSADDR_W   = 7;
	localparam int IOEXP_BUSADDR_LSB = 1;
	localparam int IOEXP_BUSADDR_PITCH = 8;
	localparam int IOEXP_PER_BANK    = 4;
	localparam int IOEXP_MAX_EXP     = 5;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] IOEXP_PIN_RST  = 16'h0000;
	localparam logic [6:0]  IOEXP_ADDR_RST = 7'h00;
	localparam logic [3:0]  IOEXP_SEL_RST  = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Request to the bus master engine
	typedef struct packed {
		logic [6:0]  busAddr;
		logic [2:0]  expander;
		logic [15:0] outValue;
		logic        testMode;
	} ioexp_req_t;

	// Register bus read and write group
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} ioexp_bus_t;

	typedef enum logic [1:0] {
		IOEXP_IDLE = 2'b01,
		IOEXP_BUSY = 2'b10
	} ioexp_state_t;

endpackage : ioexp_pkg

// ===== src/ioexp_access_reg.sv
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module ioexp_access_reg
	import ioexp_pkg::*;
#(
	parameter int N_EXP = IOEXP_MAX_EXP
)
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Register port
	input  wire ioexp_bus_t            bus,
	output      logic [31:0]           rdata,
	// Core pin values and direction, one entry per expander
	input  wire logic [N_EXP-1:0][15:0] coreOut,
	input  wire logic [N_EXP-1:0][15:0] outMask,
	// Bus master engine link
	output      logic                  smbStart,
	output      ioexp_req_t            smbReq,
	input  wire logic                  smbDone,
	input  wire logic [15:0]           smbRdData,
	// Interrupt
	output      logic                  irq
);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration check: address bank layout holds five expanders
	// The request's three-bit index would allow eight; the read-back bank layout sets five as the ceiling
	if (N_EXP < 1 || N_EXP > IOEXP_MAX_EXP)
	begin : gBadN
		$error("N_EXP out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	ioexp_state_t state;
	ioexp_state_t next_state;
	logic [15:0]  cache [N_EXP];
	logic [6:0]   busAddr [N_EXP];
	logic [3:0]   sel;
	logic         testMode;
	logic         doneFlag;
	logic         irqStatus;
	logic         irqMask;
	logic         ctrlWr;
	logic         bank0Wr;
	logic         bank1Wr;
	logic         stWr;
	logic         mkWr;
	logic [3:0]   wSel;
	logic         wTest;
	logic         wSelValid;
	logic         selValid;
	logic         launch;
	logic         doneEvent;
	logic [15:0]  selPins;
	logic [15:0]  sendOut;
	logic [31:0]  bank0Rd;
	logic [31:0]  bank1Rd;
	logic [31:0]  next_rdata;

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	// One strobe hits at most one register, so the chain needs no priority
	always_comb
	begin
		ctrlWr  = 1'b0;
		bank0Wr = 1'b0;
		bank1Wr = 1'b0;
		stWr    = 1'b0;
		mkWr    = 1'b0;
		if (bus.wr && bus.addr == IOEXP_CTRL_OFS)
			ctrlWr = 1'b1;
		else if (bus.wr && bus.addr == IOEXP_ADDR0_OFS)
			bank0Wr = 1'b1;
		else if (bus.wr && bus.addr == IOEXP_ADDR1_OFS)
			bank1Wr = 1'b1;
		else if (bus.wr && bus.addr == IOEXP_IRQST_OFS)
			stWr = 1'b1;
		else if (bus.wr && bus.addr == IOEXP_IRQMK_OFS)
			mkWr = 1'b1;
	end

	// Fields of the incoming control write
	assign wSel  = bus.wdata[IOEXP_SEL_LSB +: IOEXP_SEL_W];
	assign wTest = bus.wdata[IOEXP_TEST_BIT];
	assign wSelValid = (wSel < 4'(N_EXP));
	assign selValid  = (sel < 4'(N_EXP));

	////////////////////////////////////////////////////////////////////////////
	// Select and test mode fields
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sel      <= IOEXP_SEL_RST;
			testMode <= 1'b0;
		end
		else if (ctrlWr)
		begin
			sel      <= wSel;
			testMode <= wTest;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-expander pin cache and bus address
	for (genvar g = 0; g < N_EXP; g++)
	begin : gExp
		localparam int BANK = g / IOEXP_PER_BANK;
		localparam int POS  = (g % IOEXP_PER_BANK) * IOEXP_BUSADDR_PITCH + IOEXP_BUSADDR_LSB;

		// Completion wins over a same-cycle test write: it is the newer image
		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
				cache[g] <= IOEXP_PIN_RST;
			else if (doneEvent && smbReq.expander == 3'(g))
				cache[g] <= (smbRdData & ~outMask[g]) | (smbReq.outValue & outMask[g]);
			else if (ctrlWr && wTest && wSel == 4'(g))
				cache[g] <= (cache[g] & ~outMask[g]) | (bus.wdata[15:0] & outMask[g]);
		end

		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
				busAddr[g] <= IOEXP_ADDR_RST;
			else if ((BANK == 0 && bank0Wr) || (BANK == 1 && bank1Wr))
				busAddr[g] <= bus.wdata[POS +: IOEXP_BUSADDR_W];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin image of the selected expander
	always_comb
	begin
		selPins = 16'h0000;
		if (selValid)
			selPins = cache[3'(sel)];
	end

	// Output values sent with a refresh of the written expander
	// Sampled at the write itself, so later core changes do not leak in
	always_comb
	begin
		sendOut = 16'h0000;
		if (wSelValid)
		begin
			if (wTest)
				sendOut = bus.wdata[15:0] & outMask[3'(wSel)];
			else
				sendOut = coreOut[3'(wSel)] & outMask[3'(wSel)];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transaction control
	// Launch only from idle: the engine serves one transaction at a time
	// Refresh bit launches
	assign launch    = ctrlWr && bus.wdata[IOEXP_REFRESH_BIT] && wSelValid && state == IOEXP_IDLE;
	// A stray done while idle is ignored
	assign doneEvent = smbDone && state == IOEXP_BUSY;

	always_comb
	begin
		next_state = state;
		case (state)
			IOEXP_IDLE:
				if (launch)
					next_state = IOEXP_BUSY;
			IOEXP_BUSY:
				if (smbDone)
					next_state = IOEXP_IDLE;
			default:
				next_state = IOEXP_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state <= IOEXP_IDLE;
		else
			state <= next_state;
	end

	// A refresh written while busy is dropped, not queued
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			smbStart <= 1'b0;
			smbReq   <= '0;
		end
		else
		begin
			smbStart <= launch;
			if (launch)
			begin
				smbReq.busAddr  <= busAddr[3'(wSel)];
				smbReq.expander <= 3'(wSel);
				smbReq.outValue <= sendOut;
				smbReq.testMode <= wTest;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Completion flag and interrupt
	// Done only reports the expander that is still selected
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			doneFlag <= 1'b0;
		else if (doneEvent && selValid && smbReq.expander == 3'(sel))
			doneFlag <= 1'b1;
		else if (ctrlWr && bus.wdata[IOEXP_DONE_BIT])
			doneFlag <= 1'b0;
	end

	// Sticky status, set on every completion
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irqStatus <= 1'b0;
		else if (doneEvent)
			irqStatus <= 1'b1;
		else if (stWr && bus.wdata[0])
			irqStatus <= 1'b0;
	end

	// Mask register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			irqMask <= 1'b0;
		else if (mkWr)
			irqMask <= bus.wdata[0];
	end

	// Level output, high while the unmasked status stands
	assign irq = irqStatus & irqMask;

	////////////////////////////////////////////////////////////////////////////
	// Read path
	// The second bank carries only the fifth expander address
	always_comb
	begin
		bank0Rd = 32'h0000_0000;
		bank1Rd = 32'h0000_0000;
		for (int i = 0; i < N_EXP; i++)
		begin
			if (i < IOEXP_PER_BANK)
				bank0Rd[i * IOEXP_BUSADDR_PITCH + IOEXP_BUSADDR_LSB +: IOEXP_BUSADDR_W] = busAddr[i];
			else
				bank1Rd[IOEXP_BUSADDR_LSB +: IOEXP_BUSADDR_W] = busAddr[i];
		end
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (bus.addr == IOEXP_CTRL_OFS)
		begin
			next_rdata[15:0] = selPins;
			next_rdata[IOEXP_REFRESH_BIT] = 1'b0;
			next_rdata[IOEXP_TEST_BIT] = testMode;
			next_rdata[IOEXP_SEL_LSB +: IOEXP_SEL_W] = sel;
			next_rdata[IOEXP_DONE_BIT] = doneFlag;
		end
		else if (bus.addr == IOEXP_ADDR0_OFS)
			next_rdata = bank0Rd;
		else if (bus.addr == IOEXP_ADDR1_OFS)
			next_rdata = bank1Rd;
		else if (bus.addr == IOEXP_IRQST_OFS)
			next_rdata[0] = irqStatus;
		else if (bus.addr == IOEXP_IRQMK_OFS)
			next_rdata[0] = irqMask;
	end

	// Read data held only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 32'h0000_0000;
		else if (bus.rd)
			rdata <= next_rdata;
		else
			rdata <= 32'h0000_0000;
	end

endmodule : ioexp_access_reg

// ===== test/ioexp_asserts.sv
`timescale 1ns/100ps
module ioexp_asserts
	import ioexp_pkg::*;
#(
	parameter int N_EXP = IOEXP_MAX_EXP
)
(
	// Clock, reset, register port
	input wire logic                   clk,
	input wire logic                   rst,
	input wire ioexp_bus_t             bus,
	input wire logic [31:0]            rdata,
	// Core side
	input wire logic [N_EXP-1:0][15:0] coreOut,
	input wire logic [N_EXP-1:0][15:0] outMask,
	// Engine link and interrupt
	input wire logic                   smbStart,
	input wire ioexp_req_t             smbReq,
	input wire logic                   smbDone,
	input wire logic [15:0]            smbRdData,
	input wire logic                   irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	//////////////////////////////
	a_rd_idle: assert property (!$past(bus.rd) |-> rdata == 0)
		else $error("read data outside read slot");
	a_trig_zero: assert property ($past(bus.rd) |-> !rdata[24])
		else $error("refresh bit read as one");
	a_start_once: assert property (smbStart |=> !smbStart)
		else $error("launch longer than one cycle");
	a_start_cause: assert property (smbStart |->
		$past(bus.wr && bus.wdata[24] && bus.addr == IOEXP_CTRL_OFS))
		else $error("launch without refresh write");
	a_rsvd_quiet: assert property (bus.wr && bus.addr == IOEXP_CTRL_OFS
		&& bus.wdata[29:26] >= N_EXP |=> !smbStart)
		else $error("launch on reserved select");
	a_req_sel: assert property (smbStart |->
		smbReq.expander == $past(bus.wdata[28:26])
		&& smbReq.testMode == $past(bus.wdata[25]))
		else $error("request select or mode wrong");
	a_test_out: assert property (smbStart && smbReq.testMode |->
		smbReq.outValue == $past(bus.wdata[15:0] & outMask[bus.wdata[29:26]]))
		else $error("test mode outputs wrong");
	a_core_out: assert property (smbStart && !smbReq.testMode |->
		smbReq.outValue == $past(coreOut[bus.wdata[29:26]] & outMask[bus.wdata[29:26]]))
		else $error("core outputs wrong");
	// Main scenarios reached
	c_test: cover property (smbStart && smbReq.testMode);
	c_done: cover property (smbDone);
	c_irq: cover property (irq);
endmodule : ioexp_asserts
bind ioexp_access_reg ioexp_asserts #(.N_EXP(N_EXP)) chk (.clk(clk), .rst(rst),
	.bus(bus), .rdata(rdata), .coreOut(coreOut), .outMask(outMask),
	.smbStart(smbStart), .smbReq(smbReq), .smbDone(smbDone),
	.smbRdData(smbRdData), .irq(irq));

// ===== test/ioexp_engine_model.sv
`timescale 1ns/100ps
module ioexp_engine_model
	import ioexp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Launch, pad levels, reply delay
	input  wire logic        smbStart,
	input  wire logic [15:0] padIn,
	input  wire logic [3:0]  lag,
	// Reply
	output      logic        smbDone,
	output      logic [15:0] smbRdData
);
	int left;
	//////////////////////////////
	// answer each launch
	// Data churns off the done cycle so stale values never match
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			left <= 0;
			smbDone <= 1'b0;
			smbRdData <= 16'h0000;
		end
		else
		begin
			smbDone <= (left == 1);
			smbRdData <= (left == 1) ? padIn : ~smbRdData;
			if (smbStart)
				left <= lag + 2;
			else if (left > 0)
				left <= left - 1;
		end
	end
endmodule : ioexp_engine_model

// ===== test/tb.sv
`timescale 1ns/100ps
module tb
	import ioexp_pkg::*;
;
	logic             clk = 0, rst = 1, irq, smbStart, smbDone;
	ioexp_bus_t       bus = '0;
	logic [31:0]      rdata, got;
	logic [4:0][15:0] coreOut, outMask;
	logic [15:0]      smbRdData, padIn = 0, p, cache [5];
	ioexp_req_t       smbReq;
	logic [3:0]       lag = 0;
	int               fails = 0, checksDone = 0, cyc = 0;
	ioexp_access_reg dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
		.coreOut(coreOut), .outMask(outMask), .smbStart(smbStart), .smbReq(smbReq),
		.smbDone(smbDone), .smbRdData(smbRdData), .irq(irq));
	ioexp_engine_model far (.clk(clk), .rst(rst), .smbStart(smbStart), .padIn(padIn),
		.lag(lag), .smbDone(smbDone), .smbRdData(smbRdData));
	initial forever #5 clk = ~clk;
	// Hang guard
	always @(posedge clk)
		if (++cyc == 20000)
		begin
			fails++;
			end_sim();
		end
	//////////////////////////////
	task automatic chk(input logic [31:0] g, e);
		checksDone++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk) bus <= '{1'b1, 1'b0, a, d};
		@(posedge clk) bus.wr <= 1'b0;
	endtask : wr
	// Read data lands one cycle after the strobe
	task automatic rd(input logic [11:0] a);
		@(posedge clk) bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk) bus.rd <= 1'b0;
		#1 got = rdata;
	endtask : rd
	function automatic logic [31:0] img(int s, logic t, logic d);
		return {d, 1'b0, 4'(s), t, 9'h000, (s < 5) ? cache[s] : 16'h0000};
	endfunction : img
	task automatic ctl(int s, logic t, logic r, logic [15:0] v);
		wr(IOEXP_CTRL_OFS, {1'b1, 1'b0, 4'(s), t, r, 8'h00, v});
	endtask : ctl
	// Bounded wait, then output image from the mask
	task automatic refresh(int s, logic t, logic [15:0] v);
		logic [15:0] o;
		int n;
		o = (t ? v : coreOut[s]) & outMask[s];
		lag = 4'($urandom);
		padIn = 16'($urandom);
		ctl(s, t, 1'b1, v);
		#1 n = 0;
		while (smbStart !== 1'b1 && n++ < 9) @(posedge clk) #1;
		chk(32'(smbReq.busAddr), 32'(7'h20 + s));
		chk(32'(smbReq.outValue), 32'(o));
		while (smbDone !== 1'b1 && n++ < 40) @(posedge clk) #1;
		cache[s] = (padIn & ~outMask[s]) | o;
		rd(IOEXP_CTRL_OFS);
		chk(got, img(s, t, 1'b1));
	endtask : refresh
	task automatic end_sim();
		$display("checks %0d fails %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	//////////////////////////////
	initial
	begin
		void'($urandom(32'h08e9e111));
		for (int i = 0; i < 5; i++)
		begin
			coreOut[i] <= 16'($urandom);
			outMask[i] <= 16'($urandom);
			cache[i] = 16'h0000;
		end
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(IOEXP_CTRL_OFS);
		chk(got, 32'h0000_0000);
		rd(12'h0100);
		chk(got, 32'h0000_0000);
		wr(IOEXP_ADDR0_OFS, 32'h4644_4240);
		wr(IOEXP_ADDR1_OFS, 32'h0000_0048);
		wr(IOEXP_IRQMK_OFS, 32'h0000_0001);
		for (int s = 0; s < 5; s++)
			refresh(s, 1'b0, 16'($urandom));
		#1 chk(32'(irq), 1);
		wr(IOEXP_IRQST_OFS, 32'h0000_0001);
		#1 chk(32'(irq), 0);
		$display("test refresh done");
		ctl(2, 1'b0, 1'b0, 16'hffff);
		rd(IOEXP_CTRL_OFS);
		chk(got, img(2, 1'b0, 1'b0));
		p = 16'($urandom);
		ctl(2, 1'b1, 1'b0, p);
		cache[2] = (cache[2] & ~outMask[2]) | (p & outMask[2]);
		rd(IOEXP_CTRL_OFS);
		chk(got, img(2, 1'b1, 1'b0));
		refresh(3, 1'b1, 16'($urandom));
		$display("test override done");
		for (int s = 5; s < 16; s++)
		begin
			ctl(s, 1'b0, 1'b1, 16'hffff);
			rd(IOEXP_CTRL_OFS);
			chk(got, img(s, 1'b0, 1'b0));
		end
		$display("test reserved done");
		end_sim();
	end
endmodule : tb
